//--- rtl/fpr_defs.svh
// Constants for the floating-point rounding control block
// Assumes byte offsets on a 4-bit register address
`ifndef FPR_DEFS_SVH
`define FPR_DEFS_SVH

`define FPR_ADDR_W      4
`define FPR_ADDR_SCW    4'h0
`define FPR_ADDR_SSW    4'h4
`define FPR_ADDR_SIMD   4'h8
`define FPR_ADDR_XPTR   4'hc

`define FPR_SCW_RND_LO  10
`define FPR_SCW_RND_HI  11
`define FPR_SIMD_RND_LO 13
`define FPR_SIMD_RND_HI 14
`define FPR_SCW_IM      0
`define FPR_SIMD_IM     7
`define FPR_FLG_IE      0
`define FPR_FLG_INX     5

`define FPR_SCW_RST     16'h003f
`define FPR_SSW_RST     16'h0000
`define FPR_SIMD_RST    32'h00001f80

`define FPR_QB_SGL      6'h16
`define FPR_QB_DBL      6'h33
`define FPR_QB_EXT      6'h3e
`define FPR_TOP_SGL     7'h18
`define FPR_TOP_DBL     7'h35
`define FPR_TOP_EXT     7'h40

`endif

//--- rtl/fpr_pkg.sv
// Types for the floating-point rounding control block
// Mode enum order matches the 2-bit control field encoding
package fpr_pkg;
  typedef enum logic [1:0] {FPR_RNE, FPR_RDN, FPR_RUP, FPR_RTZ} fpr_rmode_t;
  typedef enum logic {FPR_SCALAR, FPR_SIMD} fpr_unit_t;
  typedef enum logic [1:0] {FPR_ARITH, FPR_CMP, FPR_TRUNC} fpr_kind_t;
  typedef enum logic [1:0] {FPR_SGL, FPR_DBL, FPR_EXT} fpr_fmt_t;
endpackage

//--- rtl/fpr_round_core.sv
// Rounding decision from mode, sign, lsb and guard/round/sticky bits
// Purely combinational; the caller registers the result
`timescale 1ns/1ps
module fpr_round_core
  import fpr_pkg::*;
(
  input  wire fpr_pkg::fpr_rmode_t i_mode,
  input  wire logic                i_sign,
  input  wire logic                i_lsb,
  input  wire logic                i_grd,
  input  wire logic                i_rnd,
  input  wire logic                i_stk,
  output logic                     o_inc,
  output logic                     o_inexact
);
  import fpr_pkg::*;

  logic below_half;

  // Any bit below the lsb means the exact value is not representable
  assign o_inexact  = i_grd | i_rnd | i_stk;
  assign below_half = i_rnd | i_stk;

  always_comb
  begin
    o_inc = 1'b0;
    unique case (i_mode)
      FPR_RNE: o_inc = i_grd & (below_half | i_lsb);
      FPR_RDN: o_inc = i_sign & o_inexact;
      FPR_RUP: o_inc = ~i_sign & o_inexact;
      FPR_RTZ: o_inc = 1'b0;
    endcase
  end
endmodule

//--- rtl/fpr_top.sv
// Rounding, precision flag and NaN handling for the scalar and SIMD units
// Result is sign-magnitude, right aligned, with guard/round/sticky given
// by the arithmetic stage; one cycle from request to answer
`timescale 1ns/1ps
`include "fpr_defs.svh"

module fpr_top
  import fpr_pkg::*;
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic [`FPR_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [31:0]            o_rdata,
  input  wire logic                   i_op_valid,
  input  wire fpr_pkg::fpr_unit_t     i_op_unit,
  input  wire fpr_pkg::fpr_kind_t     i_op_kind,
  input  wire fpr_pkg::fpr_fmt_t      i_op_fmt,
  input  wire logic                   i_op_nan,
  input  wire logic                   i_op_invalid,
  input  wire logic [31:0]            i_opnd_addr,
  input  wire logic                   i_res_sign,
  input  wire logic [63:0]            i_res_keep,
  input  wire logic                   i_res_grd,
  input  wire logic                   i_res_rnd,
  input  wire logic                   i_res_stk,
  output logic                        o_res_valid,
  output logic                        o_res_sign,
  output logic      [63:0]            o_res_sig,
  output logic                        o_res_carry,
  output logic                        o_res_nan,
  output logic                        o_res_inexact,
  output logic                        o_trap
);
  import fpr_pkg::*;

  logic [15:0] scw_reg;
  logic [15:0] ssw_reg;
  logic [31:0] simd_fp_ctrl_stat_reg;
  logic [31:0] xptr_reg;
  fpr_fmt_t    res_fmt_reg;

  fpr_rmode_t  round_select_field;
  fpr_rmode_t  scalar_rsel;
  fpr_rmode_t  simd_rsel;
  logic        rnd_inc;
  logic        rnd_inexact;
  logic        inv_masked;
  logic        is_snan;
  logic        nan_path;
  logic        inv_hit;
  logic        trap_next;
  logic        round_path;
  logic        inexact_hit;
  logic [64:0] rnd_sum;
  logic [63:0] qbit_mask;

  function automatic logic [5:0] quiet_pos(input fpr_fmt_t f);
    unique case (f)
      FPR_SGL: quiet_pos = `FPR_QB_SGL;
      FPR_DBL: quiet_pos = `FPR_QB_DBL;
      default: quiet_pos = `FPR_QB_EXT;
    endcase
  endfunction

  function automatic logic [6:0] carry_pos(input fpr_fmt_t f);
    unique case (f)
      FPR_SGL: carry_pos = `FPR_TOP_SGL;
      FPR_DBL: carry_pos = `FPR_TOP_DBL;
      default: carry_pos = `FPR_TOP_EXT;
    endcase
  endfunction

  // Each unit reads only its own field
  assign scalar_rsel = fpr_rmode_t'(scw_reg[`FPR_SCW_RND_HI:`FPR_SCW_RND_LO]);
  assign simd_rsel   = fpr_rmode_t'(simd_fp_ctrl_stat_reg[`FPR_SIMD_RND_HI:`FPR_SIMD_RND_LO]);

  always_comb
  begin
    round_select_field = (i_op_unit == FPR_SCALAR) ? scalar_rsel : simd_rsel;
    if (i_op_kind == FPR_TRUNC)
    begin
      round_select_field = FPR_RTZ;
    end
  end

  fpr_round_core u_round (
    .i_mode    (round_select_field),
    .i_sign    (i_res_sign),
    .i_lsb     (i_res_keep[0]),
    .i_grd     (i_res_grd),
    .i_rnd     (i_res_rnd),
    .i_stk     (i_res_stk),
    .o_inc     (rnd_inc),
    .o_inexact (rnd_inexact)
  );

  assign qbit_mask   = 64'h1 << quiet_pos(i_op_fmt);
  assign is_snan     = i_op_nan & ~|(i_res_keep & qbit_mask);
  assign inv_masked  = (i_op_unit == FPR_SCALAR) ? scw_reg[`FPR_SCW_IM] : simd_fp_ctrl_stat_reg[`FPR_SIMD_IM];
  assign nan_path    = i_op_nan | i_op_invalid;
  assign inv_hit     = i_op_valid & (is_snan | i_op_invalid);
  assign trap_next   = inv_hit & ~inv_masked;
  // Compares and NaNs bypass rounding entirely
  assign round_path  = (i_op_kind != FPR_CMP) & ~nan_path;
  assign inexact_hit = i_op_valid & round_path & rnd_inexact;
  assign rnd_sum     = {1'b0, i_res_keep} + {64'h0, rnd_inc & round_path};

  // Result stage; a trapping operation delivers nothing
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_res_valid   <= 1'b0;
      o_res_sign    <= 1'b0;
      o_res_sig     <= 64'h0;
      o_res_carry   <= 1'b0;
      o_res_nan     <= 1'b0;
      o_res_inexact <= 1'b0;
      res_fmt_reg   <= FPR_SGL;
    end
    else
    begin
      o_res_valid   <= i_op_valid & ~trap_next;
      o_res_inexact <= inexact_hit;
      o_res_nan     <= i_op_valid & nan_path;
      res_fmt_reg   <= i_op_fmt;
      if (i_op_valid)
      begin
        if (i_op_nan)
        begin
          // Payload kept, quiet bit forced so no signaling NaN escapes
          o_res_sign  <= i_res_sign;
          o_res_sig   <= i_res_keep | qbit_mask;
          o_res_carry <= 1'b0;
        end
        else if (i_op_invalid)
        begin
          o_res_sign  <= 1'b1;
          o_res_sig   <= qbit_mask;
          o_res_carry <= 1'b0;
        end
        else
        begin
          o_res_sign  <= i_res_sign;
          o_res_sig   <= rnd_sum[63:0];
          o_res_carry <= rnd_sum[carry_pos(i_op_fmt)];
        end
      end
    end
  end

  // Trap pulse and address of the offending operand
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_trap   <= 1'b0;
      xptr_reg <= 32'h0;
    end
    else
    begin
      o_trap <= trap_next;
      if (trap_next)
      begin
        xptr_reg <= i_opnd_addr;
      end
    end
  end

  // Scalar control word
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      scw_reg <= `FPR_SCW_RST;
    end
    else if (i_wr && i_addr == `FPR_ADDR_SCW)
    begin
      scw_reg <= i_wdata[15:0];
    end
  end

  // Scalar status: write one to clear, a same-cycle event wins
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ssw_reg <= `FPR_SSW_RST;
    end
    else
    begin
      if (i_wr && i_addr == `FPR_ADDR_SSW)
      begin
        ssw_reg <= ssw_reg & ~i_wdata[15:0];
      end
      if (inexact_hit && i_op_unit == FPR_SCALAR)
      begin
        ssw_reg[`FPR_FLG_INX] <= 1'b1;
      end
      if (inv_hit && i_op_unit == FPR_SCALAR)
      begin
        ssw_reg[`FPR_FLG_IE] <= 1'b1;
      end
    end
  end

  // SIMD control/status: plain write, hardware flag sets win
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      simd_fp_ctrl_stat_reg <= `FPR_SIMD_RST;
    end
    else
    begin
      if (i_wr && i_addr == `FPR_ADDR_SIMD)
      begin
        simd_fp_ctrl_stat_reg <= i_wdata;
      end
      if (inexact_hit && i_op_unit == FPR_SIMD)
      begin
        simd_fp_ctrl_stat_reg[`FPR_FLG_INX] <= 1'b1;
      end
      if (inv_hit && i_op_unit == FPR_SIMD)
      begin
        simd_fp_ctrl_stat_reg[`FPR_FLG_IE] <= 1'b1;
      end
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_rdata <= 32'h0;
    end
    else if (i_rd)
    begin
      unique case (i_addr)
        `FPR_ADDR_SCW:  o_rdata <= {16'h0, scw_reg};
        `FPR_ADDR_SSW:  o_rdata <= {16'h0, ssw_reg};
        `FPR_ADDR_SIMD: o_rdata <= simd_fp_ctrl_stat_reg;
        `FPR_ADDR_XPTR: o_rdata <= xptr_reg;
        default:        o_rdata <= 32'h0;
      endcase
    end
    else
    begin
      o_rdata <= 32'h0;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_rne_tie_even: assert property (
    i_op_valid && round_select_field == FPR_RNE && i_res_grd && !i_res_rnd && !i_res_stk |-> rnd_inc == i_res_keep[0])
    else $error("tie not rounded to even");

  a_rdn_dir_ok: assert property (
    i_op_valid && round_select_field == FPR_RDN |-> rnd_inc == (i_res_sign && rnd_inexact))
    else $error("round down picked wrong neighbour");

  a_rup_dir_ok: assert property (
    i_op_valid && round_select_field == FPR_RUP |-> rnd_inc == (!i_res_sign && rnd_inexact))
    else $error("round up picked wrong neighbour");

  a_trunc_no_inc: assert property (
    i_op_valid && round_select_field == FPR_RTZ |-> !rnd_inc)
    else $error("truncate grew magnitude");

  a_exact_passes: assert property (
    i_op_valid && !nan_path && !rnd_inexact |=> o_res_sig == $past(i_res_keep) && !o_res_inexact)
    else $error("exact result altered");

  a_one_ulp_max: assert property (
    i_op_valid && !nan_path |=> o_res_sig - $past(i_res_keep) <= 64'h1)
    else $error("result moved more than one lsb");

  a_scalar_inx_set: assert property (
    inexact_hit && i_op_unit == FPR_SCALAR |=> ssw_reg[`FPR_FLG_INX] && o_res_inexact)
    else $error("scalar inexact flag not set");

  a_cmp_untouched: assert property (
    i_op_valid && i_op_kind == FPR_CMP && !nan_path |=> o_res_sig == $past(i_res_keep) && !o_res_inexact)
    else $error("compare result rounded");

  a_trunc_cvt_rtz: assert property (
    i_op_valid && i_op_kind == FPR_TRUNC |-> round_select_field == FPR_RTZ)
    else $error("truncating conversion not toward zero");

  a_nan_out_quiet: assert property (
    o_res_valid && o_res_nan |-> o_res_sig[quiet_pos(res_fmt_reg)])
    else $error("signaling NaN delivered");

  a_trap_ptr_addr: assert property (
    o_trap |-> xptr_reg == $past(i_opnd_addr) && !o_res_valid)
    else $error("trap without operand address");

endmodule

//--- verif/fp_rounding_control_test.sv
// Self-checking bench for the rounding control block
// Drives the register and operation ports itself; integer model of the rules
`timescale 1ns/1ps
`include "fpr_defs.svh"
module fp_rounding_control_test;
  import fpr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] oaddr = 32'h0;
  logic        wr = 1'b0, rd = 1'b0, ov = 1'b0, nan = 1'b0, inv = 1'b0;
  logic        sgn = 1'b0, g = 1'b0, r = 1'b0, s = 1'b0;
  fpr_unit_t   unit = FPR_SCALAR;
  fpr_kind_t   kind = FPR_ARITH;
  fpr_fmt_t    fmt = FPR_SGL;
  logic [63:0] keep = 64'h0;
  logic [31:0] rdata;
  logic [63:0] sig;
  logic        rv, rsign, carry, rnan, rinex, trap;
  logic [31:0] m_scw, m_ssw, m_simd, m_ptr;
  int          miscompares = 0;
  int          tests_run = 0;

  fpr_top dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_op_valid(ov), .i_op_unit(unit), .i_op_kind(kind), .i_op_fmt(fmt), .i_op_nan(nan),
    .i_op_invalid(inv), .i_opnd_addr(oaddr), .i_res_sign(sgn), .i_res_keep(keep), .i_res_grd(g),
    .i_res_rnd(r), .i_res_stk(s), .o_res_valid(rv), .o_res_sign(rsign), .o_res_sig(sig),
    .o_res_carry(carry), .o_res_nan(rnan), .o_res_inexact(rinex), .o_trap(trap));

  always #20 clk = ~clk;

  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [64:0] seen, input logic [64:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task model_rst;
    m_scw = {16'h0, `FPR_SCW_RST};
    m_ssw = {16'h0, `FPR_SSW_RST};
    m_simd = `FPR_SIMD_RST;
    m_ptr = 32'h0;
  endtask

  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Scalar status flags clear on write of one; SIMD word is a plain write; pointer is read-only
    case (a)
      `FPR_ADDR_SCW: m_scw = {16'h0, d[15:0]};
      `FPR_ADDR_SSW: m_ssw = m_ssw & ~{16'h0, d[15:0]};
      `FPR_ADDR_SIMD: m_simd = d;
      default: ;
    endcase
  endtask

  task rreg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task op(input fpr_unit_t u, input fpr_kind_t k, input fpr_fmt_t f, input logic n, input logic iv,
          input logic sn, input logic [63:0] kp, input logic gg, input logic rr, input logic ss);
    int          w;
    int          q;
    logic [1:0]  md;
    logic        inc, ix, im, bad, tx;
    logic [64:0] sum;
    logic [31:0] a;
    w = (f == FPR_SGL) ? 24 : (f == FPR_DBL) ? 53 : 64;
    q = (f == FPR_SGL) ? `FPR_QB_SGL : (f == FPR_DBL) ? `FPR_QB_DBL : `FPR_QB_EXT;
    if (w < 64)
      kp = kp & ((64'h1 << w) - 64'h1);
    a = $urandom;
    md = (u == FPR_SIMD) ? m_simd[14:13] : m_scw[11:10];
    if (k == FPR_TRUNC)
      md = 2'b11;
    im = (u == FPR_SIMD) ? m_simd[`FPR_SIMD_IM] : m_scw[`FPR_SCW_IM];
    case (md)
      2'b00: inc = gg & (rr | ss | kp[0]);
      2'b01: inc = sn & (gg | rr | ss);
      2'b10: inc = !sn & (gg | rr | ss);
      default: inc = 1'b0;
    endcase
    if (k == FPR_CMP)
      inc = 1'b0;
    ix = (gg | rr | ss) && k != FPR_CMP;
    sum = {1'b0, kp} + {64'h0, inc};
    bad = (n && !kp[q]) || iv;
    tx = bad && !im;
    @(posedge clk);
    ov <= 1'b1;
    unit <= u;
    kind <= k;
    fmt <= f;
    nan <= n;
    inv <= iv;
    sgn <= sn;
    keep <= kp;
    g <= gg;
    r <= rr;
    s <= ss;
    oaddr <= a;
    @(posedge clk);
    ov <= 1'b0;
    #1;
    if (bad && u == FPR_SIMD)
      m_simd[`FPR_FLG_IE] = 1'b1;
    else if (bad)
      m_ssw[`FPR_FLG_IE] = 1'b1;
    chk(trap, tx);
    chk(rv, !tx);
    if (tx)
      m_ptr = a;
    else if (n || iv)
    begin
      chk(rnan, 1'b1);
      chk(sig, n ? ({1'b0, kp} | (65'h1 << q)) : (65'h1 << q));
      chk(rsign, n ? sn : 1'b1);
      chk(rinex, 1'b0);
    end
    else
    begin
      chk(rnan, 1'b0);
      chk(sig, sum[63:0]);
      chk(carry, sum[w]);
      chk(rsign, sn);
      chk(rinex, ix);
      if (ix && u == FPR_SIMD)
        m_simd[`FPR_FLG_INX] = 1'b1;
      else if (ix)
        m_ssw[`FPR_FLG_INX] = 1'b1;
    end
  endtask

  initial
  begin
    #(40 * 30000);
    miscompares++;
    end_sim;
  end

  initial
  begin
    void'($urandom(37));
    model_rst;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rreg(`FPR_ADDR_SCW, m_scw);
    rreg(`FPR_ADDR_SSW, m_ssw);
    rreg(`FPR_ADDR_SIMD, m_simd);
    rreg(4'h2, 32'h0);
    wreg(`FPR_ADDR_XPTR, 32'hffffffff);
    rreg(`FPR_ADDR_XPTR, m_ptr);
    // Scalar and SIMD modes taken from separate bits of i, all 16 pairs, expose any crossed field
    for (int i = 0; i < 16; i++)
    begin
      wreg(`FPR_ADDR_SCW, 32'h003f | (i[1:0] << `FPR_SCW_RND_LO));
      wreg(`FPR_ADDR_SIMD, 32'h1f80 | (i[3:2] << `FPR_SIMD_RND_LO));
      repeat (20)
        op(fpr_unit_t'($urandom % 2), fpr_kind_t'($urandom % 3), fpr_fmt_t'($urandom % 3), 1'b0, 1'b0,
           1'($urandom), ($urandom % 4 == 0) ? 64'hffffffffffffffff : {$urandom, $urandom},
           1'($urandom), 1'($urandom), 1'($urandom));
      rreg(`FPR_ADDR_SSW, m_ssw);
      rreg(`FPR_ADDR_SIMD, m_simd);
      wreg(`FPR_ADDR_SSW, 32'h0000ffff);
    end
    op(FPR_SCALAR, FPR_ARITH, FPR_DBL, 1'b1, 1'b0, 1'b1, (64'h1 << 51) | 64'h1234, 1'b1, 1'b0, 1'b1);
    op(FPR_SIMD, FPR_ARITH, FPR_DBL, 1'b1, 1'b0, 1'b0, 64'h5, 1'b0, 1'b0, 1'b0);
    op(FPR_SCALAR, FPR_ARITH, FPR_SGL, 1'b0, 1'b1, 1'b0, 64'h77, 1'b1, 1'b1, 1'b0);
    wreg(`FPR_ADDR_SCW, m_scw & ~32'h1);
    op(FPR_SCALAR, FPR_ARITH, FPR_EXT, 1'b1, 1'b0, 1'b0, 64'h9abc, 1'b0, 1'b0, 1'b0);
    rreg(`FPR_ADDR_XPTR, m_ptr);
    wreg(`FPR_ADDR_SIMD, m_simd & ~32'h80);
    op(FPR_SIMD, FPR_ARITH, FPR_SGL, 1'b0, 1'b1, 1'b0, 64'h3, 1'b0, 1'b0, 1'b0);
    rreg(`FPR_ADDR_XPTR, m_ptr);
    rreg(`FPR_ADDR_SSW, m_ssw);
    rreg(`FPR_ADDR_SIMD, m_simd);
    // Second reset in mid-run restores defaults
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    model_rst;
    rreg(`FPR_ADDR_SCW, m_scw);
    rreg(`FPR_ADDR_SSW, m_ssw);
    rreg(`FPR_ADDR_SIMD, m_simd);
    rreg(`FPR_ADDR_XPTR, m_ptr);
    end_sim;
  end
endmodule
